// [verilog/cde_pkg.sv]
// Shared constants and types for the clear/call/decrement execution block
package cde_pkg;

	// ==================================================================
	// Widths and sizes
	localparam int DATA_W = 8;
	localparam int PC_W = 15;
	localparam int INSTR_W = 14;
	localparam int FADDR_W = 7;
	localparam int LATCH_W = 7;
	localparam int STACK_DEPTH = 16;
	localparam int REG_ADDR_W = 3;

	// ==================================================================
	// Instruction encodings (full words and opcode prefixes)
	localparam logic [13:0] OPC_CLEAR_WDOG = 14'h0064;
	localparam logic [13:0] OPC_CALL_W = 14'h000a;
	localparam logic [11:0] OPC_CLEAR_W_PFX = 12'h040; // Bits 13..2, low two ignored
	localparam logic [6:0] OPC_CLEAR_F_PFX = 7'h03; // Bits 13..7
	localparam logic [5:0] OPC_COMPL_F_PFX = 6'h09; // Bits 13..8
	localparam logic [5:0] OPC_DEC_F_PFX = 6'h03; // Bits 13..8
	localparam int DEST_BIT = 7;

	// ==================================================================
	// Register map on the software port
	localparam logic [2:0] REG_WORK = 3'h0;
	localparam logic [2:0] REG_STATUS = 3'h1;
	localparam logic [2:0] REG_PC_LATCH = 3'h2;
	localparam logic [2:0] REG_PC_LO = 3'h3;
	localparam logic [2:0] REG_PC_HI = 3'h4;

	// ==================================================================
	// Status field positions and reset values
	localparam int ST_ZERO = 0;
	localparam int ST_POWERDOWN = 3;
	localparam int ST_TIMEOUT = 4;
	localparam logic [7:0] WORK_RST = 8'h00;
	localparam logic [6:0] LATCH_RST = 7'h00;
	localparam logic [14:0] PC_RST = 15'h0000;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	localparam logic [14:0] PC_STEP = 15'h0001;

	// ==================================================================
	// Decoded operations and sequencer states
	typedef enum logic [2:0] {
		CDE_OP_NONE = 3'b000,
		CDE_OP_CLEAR_WDOG = 3'b001,
		CDE_OP_CALL_W = 3'b010,
		CDE_OP_COMPL_F = 3'b011,
		CDE_OP_CLEAR_F = 3'b100,
		CDE_OP_DEC_F = 3'b101,
		CDE_OP_CLEAR_W = 3'b110
	} cde_op_t;

	typedef enum logic [1:0] {
		CDE_S_IDLE = 2'b00,
		CDE_S_READ = 2'b01,
		CDE_S_MODIFY = 2'b10,
		CDE_S_CALL = 2'b11
	} cde_state_t;

endpackage

// [verilog/cde_return_stack.sv]
// Hardware return stack: push-only storage with a registered top entry
`timescale 1ns/10ps

module cde_return_stack #(
	parameter int DEPTH = cde_pkg::STACK_DEPTH,
	parameter int WIDTH = cde_pkg::PC_W
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic push,
	input wire logic [WIDTH-1:0] push_data,
	output logic [WIDTH-1:0] stack_top,
	output logic [$clog2(DEPTH)-1:0] stack_ptr
);

	// ==================================================================
	// State
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] entry;
		logic [$clog2(DEPTH)-1:0] ptr;
		logic [WIDTH-1:0] top;
	} cde_stk_t;

	cde_stk_t stk_reg;
	cde_stk_t stk_next;

	// Pointer wraps on overflow; the oldest entry is silently overwritten
	always_comb begin
		stk_next = stk_reg;
		if (push) begin
			stk_next.entry[stk_reg.ptr] = push_data;
			stk_next.ptr = stk_reg.ptr + 1'b1;
			stk_next.top = push_data;
		end
	end

	// Register the whole state
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			stk_reg <= '0;
		end else begin
			stk_reg <= stk_next;
		end
	end

	assign stack_top = stk_reg.top;
	assign stack_ptr = stk_reg.ptr;

endmodule

// [verilog/cde_exec.sv]
// Execution logic for watchdog clear, call via W, and file/W clear, complement, decrement
//
// Operation
// - Clear-watchdog restarts the watchdog counter at zero.
// - Clear-watchdog also zeroes the watchdog prescaler in the same operation.
// - Clear-watchdog sets timeout and powerdown flags, changing no other status bit.
// - Call via W first pushes PC plus one as the new stack top.
// - Then PC low byte comes from W, PC high bits from latch.
// - Call via W takes two cycles and leaves all status flags alone.
// - Complement inverts file register; destination select picks W or file; zero updated.
// - Clear-file writes zero to file register and sets the zero flag.
// - Decrement subtracts one; destination select picks W or file; zero updated.
// - Clear-W writes zero to W and sets the zero flag.
//
// Timing, counted from the edge that takes an instruction
// - Clear-watchdog, clear-file, clear-W and unknown words act at +1
// - Call raises the push strobe at +1; the return address reaches the stack top at +2, with the jump
// - Complement and decrement strobe a read at +1 and finish at +3
// - instr_ready stays low while a multi-cycle instruction is in flight
// - The PC advances by one for every non-call instruction, unknown ones too
//
// Limitations
// - The stack wraps after DEPTH pushes; popping belongs to the return path
// - A software write to W or a status bit loses to an instruction that writes the same bit in the same cycle
// - The watchdog counter lives outside; only its clear pulses leave here
// - The file register operand must arrive exactly one cycle after the strobe
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps

module cde_exec (
	input wire logic core_clk,
	input wire logic nrst,
	// Instruction fetch side
	input wire logic instr_valid,
	input wire logic [cde_pkg::INSTR_W-1:0] instr_word,
	output logic instr_ready,
	// Data register file side
	output logic [cde_pkg::FADDR_W-1:0] file_addr,
	output logic file_rd_en,
	input wire logic [cde_pkg::DATA_W-1:0] file_rdata,
	output logic file_wr_en,
	output logic [cde_pkg::DATA_W-1:0] file_wdata,
	// Watchdog side
	output logic watchdog_clear,
	output logic watchdog_prescaler_clear,
	// Core state seen by the rest of the core
	output logic [cde_pkg::PC_W-1:0] pc,
	output logic [cde_pkg::DATA_W-1:0] working,
	output logic [cde_pkg::PC_W-1:0] stack_top,
	output logic zero_flag,
	output logic timeout_flag,
	output logic powerdown_flag,
	// Software register port
	input wire logic [cde_pkg::REG_ADDR_W-1:0] reg_addr,
	input wire logic [cde_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [cde_pkg::DATA_W-1:0] reg_rdata
);

	// ==================================================================
	// State
	typedef struct packed {
		// Sequencer
		cde_pkg::cde_state_t state;
		cde_pkg::cde_op_t op;
		logic ready;
		// File register access
		logic [cde_pkg::FADDR_W-1:0] faddr;
		logic dest;
		logic rd_en;
		logic wr_en;
		logic [cde_pkg::DATA_W-1:0] wdata;
		// One-cycle pulses to the watchdog and the stack
		logic wdog_clr;
		logic presc_clr;
		logic push;
		logic [cde_pkg::PC_W-1:0] push_data;
		// Core state
		logic [cde_pkg::PC_W-1:0] pc;
		logic [cde_pkg::DATA_W-1:0] w;
		logic [cde_pkg::LATCH_W-1:0] pchl;
		logic z;
		logic to;
		logic pwrdn;
		// Register port read data
		logic [cde_pkg::DATA_W-1:0] rdata;
	} cde_exec_t;

	cde_exec_t st_reg;
	cde_exec_t st_next;

	logic [cde_pkg::PC_W-1:0] stk_top;

	// ==================================================================
	// Instruction decode
	function automatic cde_pkg::cde_op_t cde_decode(input logic [cde_pkg::INSTR_W-1:0] iw);
		cde_pkg::cde_op_t op;
		op = cde_pkg::CDE_OP_NONE;
		// Exact words are tested before the prefixed groups
		if (iw == cde_pkg::OPC_CLEAR_WDOG) begin
			op = cde_pkg::CDE_OP_CLEAR_WDOG;
		end else if (iw == cde_pkg::OPC_CALL_W) begin
			op = cde_pkg::CDE_OP_CALL_W;
		end else if (iw[13:2] == cde_pkg::OPC_CLEAR_W_PFX) begin
			op = cde_pkg::CDE_OP_CLEAR_W;
		end else if (iw[13:7] == cde_pkg::OPC_CLEAR_F_PFX) begin
			op = cde_pkg::CDE_OP_CLEAR_F;
		end else if (iw[13:8] == cde_pkg::OPC_COMPL_F_PFX) begin
			op = cde_pkg::CDE_OP_COMPL_F;
		end else if (iw[13:8] == cde_pkg::OPC_DEC_F_PFX) begin
			op = cde_pkg::CDE_OP_DEC_F;
		end
		return op;
	endfunction

	// Register port read mux
	function automatic logic [cde_pkg::DATA_W-1:0] cde_read_mux(
		input logic [cde_pkg::REG_ADDR_W-1:0] addr,
		input cde_exec_t s
	);
		logic [cde_pkg::DATA_W-1:0] d;
		d = cde_pkg::ZERO_BYTE;
		unique case (addr)
			cde_pkg::REG_WORK: begin
				d = s.w;
			end
			cde_pkg::REG_STATUS: begin
				d[cde_pkg::ST_ZERO] = s.z;
				d[cde_pkg::ST_POWERDOWN] = s.pwrdn;
				d[cde_pkg::ST_TIMEOUT] = s.to;
			end
			cde_pkg::REG_PC_LATCH: begin
				d = {1'b0, s.pchl};
			end
			cde_pkg::REG_PC_LO: begin
				d = s.pc[7:0];
			end
			cde_pkg::REG_PC_HI: begin
				d = {1'b0, s.pc[14:8]};
			end
			default: begin
				d = cde_pkg::ZERO_BYTE; // Unmapped offsets read as zero
			end
		endcase
		return d;
	endfunction

	// Read-modify-write result; both ops share one datapath into W or the file
	function automatic logic [cde_pkg::DATA_W-1:0] cde_modify(
		input cde_pkg::cde_op_t op,
		input logic [cde_pkg::DATA_W-1:0] data
	);
		logic [cde_pkg::DATA_W-1:0] r;
		r = data;
		if (op == cde_pkg::CDE_OP_COMPL_F) begin
			r = ~data;
		end else begin
			r = data - 8'h01;
		end
		return r;
	endfunction

	// Sequential PC advance; wraps silently at the top of the address space
	function automatic logic [cde_pkg::PC_W-1:0] cde_pc_next(
		input logic [cde_pkg::PC_W-1:0] p
	);
		return p + cde_pkg::PC_STEP;
	endfunction

	// ==================================================================
	// Next-state logic
	always_comb begin
		logic [cde_pkg::DATA_W-1:0] res;
		cde_pkg::cde_op_t dop;
		res = cde_pkg::ZERO_BYTE;
		dop = cde_decode(instr_word);
		st_next = st_reg;

		// Pulses last one cycle only
		st_next.rd_en = 1'b0;
		st_next.wr_en = 1'b0;
		st_next.wdog_clr = 1'b0;
		st_next.presc_clr = 1'b0;
		st_next.push = 1'b0;

		// Read data stand for one cycle after the strobe, zero otherwise
		st_next.rdata = reg_rd ? cde_read_mux(reg_addr, st_reg) : cde_pkg::ZERO_BYTE;

		// Software writes first, so that the core's own updates below win a tie
		if (reg_wr) begin
			unique case (reg_addr)
				cde_pkg::REG_WORK: begin
					st_next.w = reg_wdata;
				end
				cde_pkg::REG_STATUS: begin
					st_next.z = reg_wdata[cde_pkg::ST_ZERO];
					st_next.pwrdn = reg_wdata[cde_pkg::ST_POWERDOWN];
					st_next.to = reg_wdata[cde_pkg::ST_TIMEOUT];
				end
				cde_pkg::REG_PC_LATCH: begin
					st_next.pchl = reg_wdata[cde_pkg::LATCH_W-1:0];
				end
				default: begin
					st_next.pchl = st_reg.pchl; // PC and unmapped offsets are read-only
				end
			endcase
		end

		// Instruction sequencer
		unique case (st_reg.state)
			cde_pkg::CDE_S_IDLE: begin
				if (instr_valid) begin
					// Latch operands now; the fetch side may change the word next cycle
					st_next.op = dop;
					st_next.faddr = instr_word[cde_pkg::FADDR_W-1:0];
					st_next.dest = instr_word[cde_pkg::DEST_BIT];
					unique case (dop)
						cde_pkg::CDE_OP_CLEAR_WDOG: begin
							// Counter and prescaler restart together
							st_next.wdog_clr = 1'b1;
							st_next.presc_clr = 1'b1;
							st_next.to = 1'b1;
							st_next.pwrdn = 1'b1;
							st_next.pc = cde_pc_next(st_reg.pc);
						end
						cde_pkg::CDE_OP_CALL_W: begin
							// Return address goes on the stack in the first cycle
							st_next.push = 1'b1;
							st_next.push_data = cde_pc_next(st_reg.pc);
							st_next.state = cde_pkg::CDE_S_CALL;
							st_next.ready = 1'b0;
						end
						cde_pkg::CDE_OP_CLEAR_F: begin
							// No read needed: the result is known up front
							st_next.wr_en = 1'b1;
							st_next.wdata = cde_pkg::ZERO_BYTE;
							st_next.z = 1'b1;
							st_next.pc = cde_pc_next(st_reg.pc);
						end
						cde_pkg::CDE_OP_CLEAR_W: begin
							// W and zero only; the file is not touched
							st_next.w = cde_pkg::ZERO_BYTE;
							st_next.z = 1'b1;
							st_next.pc = cde_pc_next(st_reg.pc);
						end
						cde_pkg::CDE_OP_COMPL_F, cde_pkg::CDE_OP_DEC_F: begin
							// Operand fetch: read strobe now, data one cycle later
							st_next.rd_en = 1'b1;
							st_next.state = cde_pkg::CDE_S_READ;
							st_next.ready = 1'b0;
						end
						default: begin
							// Other instructions belong to other units; only step the PC
							st_next.pc = cde_pc_next(st_reg.pc);
						end
					endcase
				end
			end
			cde_pkg::CDE_S_READ: begin
				// File register data arrive in the next cycle
				st_next.state = cde_pkg::CDE_S_MODIFY;
			end
			cde_pkg::CDE_S_MODIFY: begin
				res = cde_modify(st_reg.op, file_rdata);
				// Destination select: low means W, high means file register
				if (st_reg.dest) begin
					st_next.wr_en = 1'b1;
					st_next.wdata = res;
				end else begin
					st_next.w = res;
				end
				// Only the zero flag follows the result
				st_next.z = (res == cde_pkg::ZERO_BYTE);
				st_next.pc = cde_pc_next(st_reg.pc);
				// Back to idle; the fetch side may offer the next word at once
				st_next.state = cde_pkg::CDE_S_IDLE;
				st_next.ready = 1'b1;
			end
			cde_pkg::CDE_S_CALL: begin
				// Second cycle: jump target from latch and W; flags are left as they are
				st_next.pc = {st_reg.pchl, st_reg.w};
				st_next.state = cde_pkg::CDE_S_IDLE;
				st_next.ready = 1'b1;
			end
		endcase
	end

	// ==================================================================
	// State register
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			// Pulses, strobes and operands start at zero
			st_reg <= '0;
			st_reg.state <= cde_pkg::CDE_S_IDLE;
			st_reg.op <= cde_pkg::CDE_OP_NONE;
			st_reg.ready <= 1'b1;
			st_reg.pc <= cde_pkg::PC_RST;
			st_reg.w <= cde_pkg::WORK_RST;
			st_reg.pchl <= cde_pkg::LATCH_RST;
			st_reg.to <= 1'b1; // Power-on value of the status bits
			st_reg.pwrdn <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	// ==================================================================
	// Return stack; its top is a flip-flop inside the stack
	cde_return_stack #(
		.DEPTH(cde_pkg::STACK_DEPTH),
		.WIDTH(cde_pkg::PC_W)
	) u_stack (
		.core_clk(core_clk),
		.nrst(nrst),
		.push(st_reg.push),
		.push_data(st_reg.push_data),
		.stack_top(stk_top),
		.stack_ptr()
	);

	// ==================================================================
	// Outputs, all straight from flip-flops
	// Fetch and file register side
	assign instr_ready = st_reg.ready;
	assign file_addr = st_reg.faddr;
	assign file_rd_en = st_reg.rd_en;
	assign file_wr_en = st_reg.wr_en;
	assign file_wdata = st_reg.wdata;

	// Watchdog pulses
	assign watchdog_clear = st_reg.wdog_clr;
	assign watchdog_prescaler_clear = st_reg.presc_clr;

	// Architectural state
	assign pc = st_reg.pc;
	assign working = st_reg.w;
	assign stack_top = stk_top;
	assign zero_flag = st_reg.z;
	assign timeout_flag = st_reg.to;
	assign powerdown_flag = st_reg.pwrdn;

	// Register port
	assign reg_rdata = st_reg.rdata;

endmodule

// [tb/cde_exec_props.sv]
// Assertion checker for the clear/call/decrement execution block
`timescale 1ns/10ps

module cde_exec_props (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic instr_valid,
	input wire logic [13:0] instr_word,
	input wire logic instr_ready,
	input wire logic file_rd_en,
	input wire logic [7:0] file_rdata,
	input wire logic file_wr_en,
	input wire logic [7:0] file_wdata,
	input wire logic watchdog_clear,
	input wire logic watchdog_prescaler_clear,
	input wire logic [14:0] pc,
	input wire logic [7:0] working,
	input wire logic [14:0] stack_top,
	input wire logic zero_flag,
	input wire logic timeout_flag,
	input wire logic powerdown_flag
);
	// ==========
	// Decode of the accepted instruction, mirrored from the opcode table
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);
	wire take = instr_valid && instr_ready;
	wire is_wdog = take && instr_word == cde_pkg::OPC_CLEAR_WDOG;
	wire is_call = take && instr_word == cde_pkg::OPC_CALL_W;
	wire is_clear_w = take && instr_word[13:2] == cde_pkg::OPC_CLEAR_W_PFX;
	wire is_clear_f = take && instr_word[13:7] == cde_pkg::OPC_CLEAR_F_PFX;
	wire is_compl = take && instr_word[13:8] == cde_pkg::OPC_COMPL_F_PFX;
	wire is_dec = take && instr_word[13:8] == cde_pkg::OPC_DEC_F_PFX;
	wire [2:0] flags = {zero_flag, timeout_flag, powerdown_flag};

	// ==========
	// Properties
	AST_WDOG_BOTH: assert property (watchdog_clear == watchdog_prescaler_clear)
		else $error("watchdog and prescaler clears differ");
	AST_WDOG_CAUSE: assert property (watchdog_clear |-> $past(is_wdog))
		else $error("watchdog clear without its instruction");
	AST_WDOG_EXEC: assert property (is_wdog |=> watchdog_clear && timeout_flag
		&& powerdown_flag && zero_flag == $past(zero_flag))
		else $error("watchdog clear status update wrong");
	AST_CALL_SEQ: assert property (is_call |=> (!instr_ready && $stable(flags))
		##1 (instr_ready && $stable(flags)))
		else $error("call timing or flags wrong");
	AST_CALL_TGT: assert property (is_call |-> ##2
		stack_top == $past(pc, 2) + 15'h0001 && pc[7:0] == $past(working, 2))
		else $error("call return address or target wrong");
	AST_CLEAR_F: assert property (is_clear_f |=> file_wr_en && zero_flag
		&& file_wdata == 8'h00)
		else $error("clear file result wrong");
	AST_CLEAR_W: assert property (is_clear_w |=> working == 8'h00 && zero_flag)
		else $error("clear working result wrong");
	AST_COMPL: assert property (is_compl && instr_word[7] |=> file_rd_en ##2 file_wr_en
		&& file_wdata == ~$past(file_rdata))
		else $error("complement to file wrong");
	AST_DEC: assert property (is_dec && !instr_word[7] |=> file_rd_en ##2 !file_wr_en
		&& working == $past(file_rdata) - 8'h01)
		else $error("decrement to working wrong");
	AST_ZERO: assert property (is_compl || is_dec |-> ##3
		zero_flag == (file_wr_en ? file_wdata == 8'h00 : working == 8'h00))
		else $error("zero flag after file op wrong");
endmodule

// [tb/cde_file_model.sv]
// Behavioural data register file answering the block's read and write pulses
`timescale 1ns/10ps

module cde_file_model (
	input wire logic core_clk,
	input wire logic [6:0] file_addr,
	input wire logic file_rd_en,
	input wire logic file_wr_en,
	input wire logic [7:0] file_wdata,
	output logic [7:0] file_rdata
);
	logic [7:0] mem [128];

	// Read data stand one cycle; otherwise the bus flips so stale data never look valid
	// Plain always: the bench preloads mem and file_rdata has a start value
	initial file_rdata = 8'h5a;
	always @(posedge core_clk) begin
		if (file_wr_en) begin
			mem[file_addr] <= file_wdata;
		end
		file_rdata <= file_rd_en ? mem[file_addr] : ~file_rdata;
	end
endmodule

// [tb/cde_exec_tb_top.sv]
// Self-checking bench for the clear/call/decrement execution block
`timescale 1ns/10ps

module cde_exec_tb_top;
	logic core_clk, nrst, instr_valid, instr_ready, file_rd_en, file_wr_en, reg_wr, reg_rd;
	logic watchdog_clear, watchdog_prescaler_clear, zero_flag, timeout_flag, powerdown_flag;
	logic [13:0] instr_word;
	logic [6:0] file_addr;
	logic [7:0] file_rdata, file_wdata, working, reg_wdata, reg_rdata, res;
	logic [14:0] pc, stack_top, exp_pc;
	logic [2:0] reg_addr;
	int mismatches, comparisons;

	cde_exec u_dut (.core_clk, .nrst, .instr_valid, .instr_word, .instr_ready, .file_addr,
		.file_rd_en, .file_rdata, .file_wr_en, .file_wdata, .watchdog_clear,
		.watchdog_prescaler_clear, .pc, .working, .stack_top, .zero_flag, .timeout_flag,
		.powerdown_flag, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
	cde_file_model u_mem (.core_clk, .file_addr, .file_rd_en, .file_wr_en, .file_wdata,
		.file_rdata);

	// ==========
	// Clock and shared tasks
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] seen);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic final_report();
		if (mismatches == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Offer one word; returns just after the edge that takes it
	task automatic issue(input logic [13:0] w);
		int n;
		n = 0;
		while (instr_ready !== 1'b1) begin
			n++;
			if (n > 8) begin
				mismatches++;
				final_report();
			end
			@(posedge core_clk);
			#1;
		end
		@(posedge core_clk);
		instr_valid <= 1'b1;
		instr_word <= w;
		@(posedge core_clk);
		instr_valid <= 1'b0;
		#1;
	endtask

	task automatic reg_write(input logic [2:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		#1;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic reg_read(input logic [2:0] a, input logic [7:0] exp);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		chk("reg_rdata", exp, reg_rdata);
	endtask

	// Read-modify-write op; result, destination and zero show three cycles on
	task automatic file_op(input logic [5:0] opc, input logic d, input logic [6:0] a,
		input logic [7:0] v);
		u_mem.mem[a] = v;
		res = (opc == cde_pkg::OPC_COMPL_F_PFX) ? ~v : v - 8'h01;
		issue({opc, d, a});
		exp_pc = exp_pc + 15'h0001;
		repeat (2) @(posedge core_clk);
		#1;
		chk("zero_flag", res == 8'h00, zero_flag);
		chk("pc", exp_pc, pc);
		chk("file_wr_en", d, file_wr_en);
		chk("result", res, d ? file_wdata : working);
	endtask

	// ==========
	// Main sequence
	initial begin
		nrst = 1'b0;
		instr_valid = 1'b0;
		instr_word = 14'h0000;
		reg_addr = 3'h0;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		mismatches = 0;
		comparisons = 0;
		exp_pc = 15'h0000;
		repeat (4) @(posedge core_clk);
		nrst <= 1'b1;
		#1;
		reg_read(cde_pkg::REG_STATUS, 8'h18);
		reg_read(3'h7, 8'h00);
		reg_write(cde_pkg::REG_WORK, 8'h3c);
		reg_write(cde_pkg::REG_PC_LATCH, 8'h55);
		issue({cde_pkg::OPC_CLEAR_W_PFX, 2'b11});
		chk("working", 8'h00, working);
		chk("zero_flag", 1'b1, zero_flag);
		// Clear flags by software so the watchdog clear has to set timeout and powerdown again
		reg_write(cde_pkg::REG_STATUS, 8'h00);
		reg_write(cde_pkg::REG_WORK, 8'h3c);
		issue(cde_pkg::OPC_CLEAR_WDOG);
		exp_pc = 15'h0002;
		chk("watchdog_clear", 1'b1, watchdog_clear);
		chk("prescaler_clear", 1'b1, watchdog_prescaler_clear);
		chk("flags", 3'b011, {zero_flag, timeout_flag, powerdown_flag});
		chk("pc", exp_pc, pc);
		@(posedge core_clk);
		#1;
		chk("watchdog_clear", 1'b0, watchdog_clear);
		issue(cde_pkg::OPC_CALL_W);
		chk("instr_ready", 1'b0, instr_ready);
		@(posedge core_clk);
		#1;
		chk("stack_top", exp_pc + 15'h0001, stack_top);
		chk("pc", 15'h553c, pc);
		reg_read(cde_pkg::REG_STATUS, 8'h18);
		exp_pc = 15'h553d;
		u_mem.mem[7'h22] = 8'h77;
		issue({cde_pkg::OPC_CLEAR_F_PFX, 7'h22});
		chk("clear_file", 10'h300, {file_wr_en, zero_flag, file_wdata});
		@(posedge core_clk);
		#1;
		chk("file_reg", 8'h00, u_mem.mem[7'h22]);
		file_op(cde_pkg::OPC_COMPL_F_PFX, 1'b1, 7'h10, 8'hff);
		file_op(cde_pkg::OPC_COMPL_F_PFX, 1'b0, 7'h11, 8'h5a);
		file_op(cde_pkg::OPC_DEC_F_PFX, 1'b1, 7'h7f, 8'h01);
		file_op(cde_pkg::OPC_DEC_F_PFX, 1'b0, 7'h00, 8'h00);
		// A word outside this block's set only advances the PC
		issue(14'h0000);
		chk("pc", exp_pc + 15'h0001, pc);
		chk("flags", 3'b011, {zero_flag, timeout_flag, powerdown_flag});
		// Mid-run reset returns the core to its power-on state
		@(posedge core_clk);
		nrst <= 1'b0;
		@(posedge core_clk);
		nrst <= 1'b1;
		#1;
		chk("reset_pc", {1'b1, 15'h0000}, {instr_ready, pc});
		chk("reset_flags", 3'b011, {zero_flag, timeout_flag, powerdown_flag});
		chk("reset_state", 11'h000, {watchdog_clear, file_wr_en, file_rd_en, working});
		chk("reset_stack_top", 15'h0000, stack_top);
		reg_read(cde_pkg::REG_STATUS, 8'h18);
		final_report();
	end
endmodule

bind cde_exec cde_exec_props u_props (.core_clk, .nrst, .instr_valid, .instr_word,
	.instr_ready, .file_rd_en, .file_rdata, .file_wr_en, .file_wdata, .watchdog_clear,
	.watchdog_prescaler_clear, .pc, .working, .stack_top, .zero_flag, .timeout_flag,
	.powerdown_flag);
